// ===== hw/cam_pkg.sv
// constants, types and settings layout of the camera command interpreter
// assumes one 40 MHz clock and a synchronous active-high reset
//
// Contract
// - trigger mode 0 free-run, 1 triggered
// - exposure mode two spellings: timed or width
// - trigger source codes 3,10,14,18,22 map inputs
// - software trigger command makes one trigger
// - activation 0 falling edge, 1 rising edge
// - exposure time 1 to 60,000,000 us
// - free-run starts come at frame rate
// - black level 0..255 added to pixels
// - digital gain 1x..32x, readable back
// - flat-field target auto for 0, else 1..4095
// - flat-field location select 0..11
// - save puts generated data in selected location
// - load copies stored data to working memory
// - flat-field correction enable 0 off, 1 on
// - hot-pixel correction enable 0 bypass, 1 apply
// - fan mode 0 off, 1 on, 2 temperature
// - fan target temperature -10 to 80 C
// - settings apply at frame request rising edge
// - exposure time applies at next exposure start
package cam_pkg;
    localparam int CLK_NS = 25;
    localparam int US_NS = 1000;
    localparam int US_CYC = US_NS / CLK_NS;
    localparam int FFC_LOCS = 12;

    localparam logic [7:0] OFF_TRIG_MODE = 8'h00;
    localparam logic [7:0] OFF_EXP_MODE = 8'h04;
    localparam logic [7:0] OFF_TRIG_SRC = 8'h08;
    localparam logic [7:0] OFF_SW_TRIG = 8'h0C;
    localparam logic [7:0] OFF_TRIG_ACT = 8'h10;
    localparam logic [7:0] OFF_EXP_TIME = 8'h14;
    localparam logic [7:0] OFF_FRAME_RATE = 8'h18;
    localparam logic [7:0] OFF_BLACK = 8'h1C;
    localparam logic [7:0] OFF_GAIN = 8'h20;
    localparam logic [7:0] OFF_FFC_GEN = 8'h24;
    localparam logic [7:0] OFF_FFC_SEL = 8'h28;
    localparam logic [7:0] OFF_FFC_SAVE = 8'h2C;
    localparam logic [7:0] OFF_FFC_LOAD = 8'h30;
    localparam logic [7:0] OFF_FFC_EN = 8'h34;
    localparam logic [7:0] OFF_HOT_EN = 8'h38;
    localparam logic [7:0] OFF_FAN_MODE = 8'h3C;
    localparam logic [7:0] OFF_FAN_TARGET = 8'h40;
    localparam logic [7:0] OFF_EXP_MODE2 = 8'h44;
    localparam logic [7:0] OFF_STATUS = 8'h48;

    localparam logic [31:0] EXP_MAX = 32'h03938700;
    localparam logic [31:0] FR_MAX = 32'h000003E8;
    localparam logic [31:0] BLACK_MAX = 32'h000000FF;
    localparam logic [31:0] GAIN_MAX = 32'h00000020;
    localparam logic [31:0] FFC_TGT_MAX = 32'h00000FFF;
    localparam logic [31:0] FFC_SEL_MAX = 32'h0000000B;
    localparam logic signed [31:0] FAN_T_MIN = 32'hFFFFFFF6;
    localparam logic signed [31:0] FAN_T_MAX = 32'h00000050;
    localparam logic [20:0] ONE_SEC_US = 21'h0F4240;
    localparam logic [11:0] HOT_THR = 12'h200;

    localparam logic [4:0] SRC_SW = 5'h03;
    localparam logic [4:0] SRC_USER_OUTPUT_ZERO = 5'h0A;
    localparam logic [4:0] SRC_CTRL_LINE1 = 5'h0E;
    localparam logic [4:0] SRC_TIMER_ZERO_ACTIVE = 5'h12;
    localparam logic [4:0] SRC_INPUT_LINE_ZERO = 5'h16;
    localparam logic [1:0] FAN_OFF = 2'h0;
    localparam logic [1:0] FAN_ON = 2'h1;
    localparam logic [1:0] FAN_TEMP = 2'h2;

    typedef enum logic {EXP_IDLE = 1'b0, EXP_ON = 1'b1} exp_state_e;

    typedef struct packed {
        logic trig_mode;
        logic exp_mode;
        logic [4:0] trig_src;
        logic trig_act;
        logic [9:0] frame_rate;
        logic [7:0] black;
        logic [5:0] gain;
        logic [3:0] ffc_sel;
        logic ffc_en;
        logic hot_en;
        logic [1:0] fan_mode;
        logic signed [7:0] fan_target;
    } cfg_s;

    typedef struct packed {
        logic valid;
        logic [11:0] data;
    } pix_s;

    localparam cfg_s CFG_RST = '{trig_mode: 1'b0, exp_mode: 1'b0, trig_src: 5'h03,
        trig_act: 1'b1, frame_rate: 10'h01E, black: 8'h00, gain: 6'h01, ffc_sel: 4'h0,
        ffc_en: 1'b0, hot_en: 1'b0, fan_mode: 2'h2, fan_target: 8'h28};
    localparam logic [25:0] EXP_TIME_RST = 26'h00003E8;
endpackage

// ===== hw/trig_gen.sv
// exposure trigger generator: free-run pacing, source select, edge, exposure length
// assumes a one-cycle microsecond tick; source pins are asynchronous
`timescale 1ns/10ps
module trig_gen (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic us_tick_i,
    input wire cam_pkg::cfg_s cfg_i,
    input wire logic [25:0] exp_time_i,
    input wire logic sw_trig_i,
    // user output, control line 1, timer active, input line
    input wire logic [3:0] pins_i,
    output logic expose_o,
    output logic start_o
);
    cam_pkg::exp_state_e state, next_state;
    logic [3:0] s1, s2, s3;
    logic [25:0] left, next_left;
    logic [19:0] acc, next_acc;
    logic next_start;
    logic [20:0] sum;
    logic lvl, lvl_d, edge_hit, fr_fire, start;

    always_comb begin
        lvl = 1'b0;
        lvl_d = 1'b0;
        unique case (cfg_i.trig_src)
            cam_pkg::SRC_USER_OUTPUT_ZERO: begin lvl = s2[0]; lvl_d = s3[0]; end
            cam_pkg::SRC_CTRL_LINE1: begin lvl = s2[1]; lvl_d = s3[1]; end
            cam_pkg::SRC_TIMER_ZERO_ACTIVE: begin lvl = s2[2]; lvl_d = s3[2]; end
            cam_pkg::SRC_INPUT_LINE_ZERO: begin lvl = s2[3]; lvl_d = s3[3]; end
            default: ;
        endcase
        if (cfg_i.trig_src == cam_pkg::SRC_SW) begin
            edge_hit = sw_trig_i;
        end else begin
            edge_hit = cfg_i.trig_act ? (lvl & ~lvl_d) : (~lvl & lvl_d);
        end
        sum = {1'b0, acc} + {11'h000, cfg_i.frame_rate};
        fr_fire = us_tick_i && sum >= cam_pkg::ONE_SEC_US;
        next_acc = acc;
        if (cfg_i.trig_mode || cfg_i.frame_rate == 10'h000) begin
            next_acc = '0;
        end else if (us_tick_i) begin
            next_acc = fr_fire ? 20'(sum - cam_pkg::ONE_SEC_US) : sum[19:0];
        end
        start = cfg_i.trig_mode ? edge_hit : fr_fire;
        next_state = state;
        next_left = left;
        next_start = 1'b0;
        unique case (state)
            cam_pkg::EXP_IDLE: begin
                if (start) begin
                    next_state = cam_pkg::EXP_ON;
                    next_left = exp_time_i;
                    next_start = 1'b1;
                end
            end
            cam_pkg::EXP_ON: begin
                // width exposure only makes sense for a pin source
                if (cfg_i.trig_mode && cfg_i.exp_mode && cfg_i.trig_src != cam_pkg::SRC_SW) begin
                    if (cfg_i.trig_act ? !lvl : lvl) begin
                        next_state = cam_pkg::EXP_IDLE;
                    end
                end else if (us_tick_i) begin
                    next_left = left - 26'h0000001;
                    if (left <= 26'h0000001) begin
                        next_state = cam_pkg::EXP_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            state <= cam_pkg::EXP_IDLE;
            left <= '0;
            acc <= '0;
            start_o <= 1'b0;
        end else begin
            s1 <= pins_i;
            s2 <= s1;
            s3 <= s2;
            state <= next_state;
            left <= next_left;
            acc <= next_acc;
            start_o <= next_start;
        end
    end
    assign expose_o = (state == cam_pkg::EXP_ON);

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_SW_TRIG: assert property (sw_trig_i && cfg_i.trig_mode
        && cfg_i.trig_src == cam_pkg::SRC_SW && state == cam_pkg::EXP_IDLE
        |=> start_o && expose_o)
        else $error("software trigger did not start exposure");
    AST_EXP_LATCH: assert property (start_o |-> left == $past(exp_time_i))
        else $error("exposure length not taken at start");
    AST_FREE_RUN: assert property (!cfg_i.trig_mode && !fr_fire
        && state == cam_pkg::EXP_IDLE |=> !start_o)
        else $error("free-run start without rate pacing");
    AST_TIMED_END: assert property (expose_o && us_tick_i && left == 26'h0000001
        && (!cfg_i.exp_mode || !cfg_i.trig_mode || cfg_i.trig_src == cam_pkg::SRC_SW)
        |=> !expose_o)
        else $error("timed exposure overran");
    COV_FREE_START: cover property (!cfg_i.trig_mode ##1 start_o);
endmodule

// ===== hw/pix_path.sv
// pixel correction chain: hot pixel, flat field, gain, black level
// assumes pixels arrive on the block clock; one cycle of latency
`timescale 1ns/10ps
module pix_path (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cam_pkg::cfg_s cfg_i,
    input wire logic [11:0] ffc_work_i,
    input wire cam_pkg::pix_s pix_i,
    output cam_pkg::pix_s pix_o,
    output logic [11:0] mean_o
);
    cam_pkg::pix_s next_pix;
    logic [11:0] prev, next_prev, next_mean, v;
    logic signed [14:0] f;
    logic [20:0] g;

    always_comb begin
        v = pix_i.data;
        // neighbour replace is cheap and needs no defect map
        if (cfg_i.hot_en && v > prev && (v - prev) > cam_pkg::HOT_THR) begin
            v = prev;
        end
        f = $signed({3'b000, v});
        if (cfg_i.ffc_en) begin
            f = f + $signed({3'b000, ffc_work_i}) - $signed({3'b000, mean_o});
        end
        if (f < 0) begin
            f = '0;
        end
        g = f[13:0] * cfg_i.gain + {13'h0000, cfg_i.black};
        next_pix.valid = pix_i.valid;
        next_pix.data = (g > 21'h000FFF) ? 12'hFFF : g[11:0];
        next_prev = pix_i.valid ? pix_i.data : prev;
        next_mean = mean_o;
        if (pix_i.valid) begin
            next_mean = 12'(({2'b00, mean_o, 4'h0} - {6'h00, mean_o} + {6'h00, pix_i.data}) >> 4);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pix_o <= '0;
            prev <= '0;
            mean_o <= '0;
        end else begin
            pix_o <= next_pix;
            prev <= next_prev;
            mean_o <= next_mean;
        end
    end
endmodule

// ===== hw/cam_cmd.sv
// camera command interpreter: setting and query commands as register accesses
// assumes a master that holds the strobe one cycle; read data one cycle later
`timescale 1ns/10ps
module cam_cmd (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // command port
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    output logic CMD_OK_O,
    output logic CMD_ERR_O,
    // trigger sources and frame timing
    input wire logic USER_OUTPUT_ZERO_I,
    input wire logic CTRL_LINE1_I,
    input wire logic TIMER_ZERO_ACTIVE_I,
    input wire logic INPUT_LINE_ZERO_I,
    input wire logic FRAME_REQ_I,
    output logic EXPOSE_O,
    output logic EXP_START_O,
    // pixels
    input wire cam_pkg::pix_s PIX_I,
    output cam_pkg::pix_s PIX_O,
    // fan
    input wire logic [7:0] TEMP_I,
    output logic FAN_O
);
    cam_pkg::cfg_s pend, next_pend, act, next_act;
    logic [25:0] exp_time, next_exp_time;
    logic [31:0] next_rdata;
    logic next_ok, next_err, sw_trig, next_sw_trig, last_err, next_last_err;
    logic [11:0] gen_data, next_gen_data, working, next_working, mean;
    logic [11:0] nv [cam_pkg::FFC_LOCS];
    logic [11:0] next_nv [cam_pkg::FFC_LOCS];
    logic req1, req2, req3, req_rise;
    logic [7:0] t1, t2;
    logic [5:0] us_cnt, next_us_cnt;
    logic us_tick, next_fan;

    function automatic logic set_ok(input logic [7:0] a, input logic [31:0] d);
        logic ok;
        ok = 1'b0;
        case (a)
            cam_pkg::OFF_TRIG_MODE, cam_pkg::OFF_EXP_MODE, cam_pkg::OFF_EXP_MODE2,
            cam_pkg::OFF_TRIG_ACT, cam_pkg::OFF_FFC_EN, cam_pkg::OFF_HOT_EN:
                ok = d <= 32'h00000001;
            cam_pkg::OFF_TRIG_SRC:
                ok = d == 32'h00000003 || d == 32'h0000000A || d == 32'h0000000E
                    || d == 32'h00000012 || d == 32'h00000016;
            cam_pkg::OFF_SW_TRIG, cam_pkg::OFF_FFC_SAVE, cam_pkg::OFF_FFC_LOAD:
                ok = 1'b1;
            cam_pkg::OFF_EXP_TIME: ok = d != '0 && d <= cam_pkg::EXP_MAX;
            cam_pkg::OFF_FRAME_RATE: ok = d != '0 && d <= cam_pkg::FR_MAX;
            cam_pkg::OFF_BLACK: ok = d <= cam_pkg::BLACK_MAX;
            cam_pkg::OFF_GAIN: ok = d != '0 && d <= cam_pkg::GAIN_MAX;
            cam_pkg::OFF_FFC_GEN: ok = d <= cam_pkg::FFC_TGT_MAX;
            cam_pkg::OFF_FFC_SEL: ok = d <= cam_pkg::FFC_SEL_MAX;
            cam_pkg::OFF_FAN_MODE: ok = d <= 32'h00000002;
            cam_pkg::OFF_FAN_TARGET:
                ok = $signed(d) >= cam_pkg::FAN_T_MIN && $signed(d) <= cam_pkg::FAN_T_MAX;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // microsecond tick for exposure and frame-rate counts
    always_comb begin
        us_tick = (us_cnt == 6'(cam_pkg::US_CYC - 1));
        next_us_cnt = us_tick ? 6'h00 : us_cnt + 6'h01;
    end

    // command decode: sets update the stored values, queries read them back
    always_comb begin
        next_pend = pend;
        next_exp_time = exp_time;
        next_rdata = '0;
        next_ok = 1'b0;
        next_err = 1'b0;
        next_sw_trig = 1'b0;
        next_last_err = last_err;
        next_gen_data = gen_data;
        next_working = working;
        next_nv = nv;
        if (WR_I) begin
            if (set_ok(ADDR_I, WDATA_I)) begin
                next_ok = 1'b1;
                next_last_err = 1'b0;
                case (ADDR_I)
                    cam_pkg::OFF_TRIG_MODE: next_pend.trig_mode = WDATA_I[0];
                    cam_pkg::OFF_EXP_MODE,
                    cam_pkg::OFF_EXP_MODE2: next_pend.exp_mode = WDATA_I[0];
                    cam_pkg::OFF_TRIG_SRC: next_pend.trig_src = WDATA_I[4:0];
                    cam_pkg::OFF_SW_TRIG: next_sw_trig = 1'b1;
                    cam_pkg::OFF_TRIG_ACT: next_pend.trig_act = WDATA_I[0];
                    cam_pkg::OFF_EXP_TIME: next_exp_time = WDATA_I[25:0];
                    cam_pkg::OFF_FRAME_RATE: next_pend.frame_rate = WDATA_I[9:0];
                    cam_pkg::OFF_BLACK: next_pend.black = WDATA_I[7:0];
                    cam_pkg::OFF_GAIN: next_pend.gain = WDATA_I[5:0];
                    cam_pkg::OFF_FFC_GEN: begin
                        // auto target takes the running scene mean as it stands at this command
                        next_gen_data = (WDATA_I[11:0] == 12'h000) ? mean : WDATA_I[11:0];
                    end
                    cam_pkg::OFF_FFC_SEL: next_pend.ffc_sel = WDATA_I[3:0];
                    cam_pkg::OFF_FFC_SAVE: next_nv[pend.ffc_sel] = gen_data;
                    cam_pkg::OFF_FFC_LOAD: next_working = nv[pend.ffc_sel];
                    cam_pkg::OFF_FFC_EN: next_pend.ffc_en = WDATA_I[0];
                    cam_pkg::OFF_HOT_EN: next_pend.hot_en = WDATA_I[0];
                    cam_pkg::OFF_FAN_MODE: next_pend.fan_mode = WDATA_I[1:0];
                    cam_pkg::OFF_FAN_TARGET: next_pend.fan_target = WDATA_I[7:0];
                    default: ;
                endcase
            end else begin
                next_err = 1'b1;
                next_last_err = 1'b1;
            end
        end
        if (RD_I) begin
            case (ADDR_I)
                cam_pkg::OFF_TRIG_MODE: next_rdata = {31'h0, pend.trig_mode};
                cam_pkg::OFF_EXP_MODE,
                cam_pkg::OFF_EXP_MODE2: next_rdata = {31'h0, pend.exp_mode};
                cam_pkg::OFF_TRIG_SRC: next_rdata = {27'h0, pend.trig_src};
                cam_pkg::OFF_TRIG_ACT: next_rdata = {31'h0, pend.trig_act};
                cam_pkg::OFF_EXP_TIME: next_rdata = {6'h0, exp_time};
                cam_pkg::OFF_FRAME_RATE: next_rdata = {22'h0, pend.frame_rate};
                cam_pkg::OFF_BLACK: next_rdata = {24'h0, pend.black};
                cam_pkg::OFF_GAIN: next_rdata = {26'h0, pend.gain};
                cam_pkg::OFF_FFC_GEN: next_rdata = {20'h0, gen_data};
                cam_pkg::OFF_FFC_SEL: next_rdata = {28'h0, pend.ffc_sel};
                cam_pkg::OFF_FFC_EN: next_rdata = {31'h0, pend.ffc_en};
                cam_pkg::OFF_HOT_EN: next_rdata = {31'h0, pend.hot_en};
                cam_pkg::OFF_FAN_MODE: next_rdata = {30'h0, pend.fan_mode};
                cam_pkg::OFF_FAN_TARGET: next_rdata = {{24{pend.fan_target[7]}}, pend.fan_target};
                cam_pkg::OFF_STATUS: next_rdata = {29'h0, FAN_O, EXPOSE_O, last_err};
                default: next_rdata = '0;
            endcase
        end
    end

    // settings go live only on a frame request so a frame never sees a mix
    always_comb begin
        req_rise = req2 & ~req3;
        next_act = req_rise ? pend : act;
    end

    // fan follows temperature with no band; holds its state when equal
    always_comb begin
        next_fan = FAN_O;
        unique case (act.fan_mode)
            cam_pkg::FAN_OFF: next_fan = 1'b0;
            cam_pkg::FAN_ON: next_fan = 1'b1;
            cam_pkg::FAN_TEMP: begin
                if ($signed(t2) > act.fan_target) begin
                    next_fan = 1'b1;
                end else if ($signed(t2) < act.fan_target) begin
                    next_fan = 1'b0;
                end
            end
            default: next_fan = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            pend <= cam_pkg::CFG_RST;
            act <= cam_pkg::CFG_RST;
            exp_time <= cam_pkg::EXP_TIME_RST;
            RDATA_O <= '0;
            CMD_OK_O <= 1'b0;
            CMD_ERR_O <= 1'b0;
            sw_trig <= 1'b0;
            last_err <= 1'b0;
            gen_data <= '0;
            working <= '0;
            nv <= '{default: '0};
            req1 <= 1'b0;
            req2 <= 1'b0;
            req3 <= 1'b0;
            t1 <= '0;
            t2 <= '0;
            us_cnt <= '0;
            FAN_O <= 1'b0;
        end else begin
            pend <= next_pend;
            act <= next_act;
            exp_time <= next_exp_time;
            RDATA_O <= next_rdata;
            CMD_OK_O <= next_ok;
            CMD_ERR_O <= next_err;
            sw_trig <= next_sw_trig;
            last_err <= next_last_err;
            gen_data <= next_gen_data;
            working <= next_working;
            nv <= next_nv;
            req1 <= FRAME_REQ_I;
            req2 <= req1;
            req3 <= req2;
            t1 <= TEMP_I;
            t2 <= t1;
            us_cnt <= next_us_cnt;
            FAN_O <= next_fan;
        end
    end

    trig_gen u_trig (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .us_tick_i(us_tick),
        .cfg_i(act),
        .exp_time_i(exp_time),
        .sw_trig_i(sw_trig),
        .pins_i({INPUT_LINE_ZERO_I, TIMER_ZERO_ACTIVE_I, CTRL_LINE1_I, USER_OUTPUT_ZERO_I}),
        .expose_o(EXPOSE_O),
        .start_o(EXP_START_O)
    );

    pix_path u_pix (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .cfg_i(act),
        .ffc_work_i(working),
        .pix_i(PIX_I),
        .pix_o(PIX_O),
        .mean_o(mean)
    );

    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    AST_SET_OK: assert property (WR_I && set_ok(ADDR_I, WDATA_I) |=> CMD_OK_O && !CMD_ERR_O)
        else $error("valid set not acknowledged");
    AST_BAD_SRC: assert property (WR_I && ADDR_I == cam_pkg::OFF_TRIG_SRC
        && WDATA_I == 32'h4 |=> CMD_ERR_O && $stable(pend.trig_src))
        else $error("bad trigger source accepted");
    AST_GAIN_READ: assert property (RD_I && ADDR_I == cam_pkg::OFF_GAIN
        |=> RDATA_O == {26'h0, $past(pend.gain)})
        else $error("gain query wrong");
    AST_APPLY: assert property (req_rise |=> act == $past(pend))
        else $error("settings not applied at frame request");
    AST_HOLD: assert property (!req_rise |=> $stable(act))
        else $error("settings changed between frame requests");
    AST_FAN_OFF: assert property (act.fan_mode == cam_pkg::FAN_OFF [*2] |-> !FAN_O)
        else $error("fan running in off mode");
    AST_SAVE: assert property (WR_I && ADDR_I == cam_pkg::OFF_FFC_SAVE
        |=> nv[$past(pend.ffc_sel)] == $past(gen_data))
        else $error("flat-field save lost");
    AST_LOAD: assert property (WR_I && ADDR_I == cam_pkg::OFF_FFC_LOAD
        |=> working == $past(nv[pend.ffc_sel]))
        else $error("flat-field load lost");
    COV_APPLY: cover property (WR_I && set_ok(ADDR_I, WDATA_I) ##[1:20] req_rise);
    COV_SW: cover property (WR_I && ADDR_I == cam_pkg::OFF_SW_TRIG ##[1:4] EXP_START_O);
    COV_REJECT: cover property (CMD_ERR_O);
endmodule

// ===== test/cmd_host.sv
// host model: issues set and query commands on the command port
// assumes each strobe is taken at the next rising edge and answered right after that same edge
`timescale 1ns/10ps
module cmd_host (
    // clock
    input wire logic clk_i,
    // command port
    output logic [7:0] addr_o,
    output logic [31:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [31:0] rdata_i,
    input wire logic ok_i,
    input wire logic err_i
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 32'h00000000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // the answer stands one cycle only, so it is caught right after the taking edge
    task automatic put(input logic [7:0] a, input logic [31:0] d, output logic ok,
                       output logic err);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        // released fields flip so a stale value never passes for a held one
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
        ok = ok_i;
        err = err_i;
    endtask
    task automatic get(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask
endmodule

// ===== test/testbench.sv
// testbench of the command interpreter: command table, then trigger, pixel and fan cases
// assumes the host model drives the command port; 40 MHz clock
`timescale 1ns/10ps
module testbench;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic ok; logic [31:0] r;} row_s;
    logic CLK_I, RST_I, WR_I, RD_I, CMD_OK_O, CMD_ERR_O, FRAME_REQ_I, FAN_O;
    logic USER_OUTPUT_ZERO_I, CTRL_LINE1_I, TIMER_ZERO_ACTIVE_I, INPUT_LINE_ZERO_I;
    logic EXPOSE_O, EXP_START_O;
    logic [7:0] ADDR_I, TEMP_I;
    logic [31:0] WDATA_I, RDATA_O, rd;
    cam_pkg::pix_s PIX_I, PIX_O;
    logic ok, err;
    int mismatches = 0, checked = 0, n;
    row_s rows [0:36] = '{
        '{8'h00, 32'h1, 1'b1, 32'h1}, '{8'h00, 32'h2, 1'b0, 32'h1},
        '{8'h04, 32'h1, 1'b1, 32'h1}, '{8'h44, 32'h1, 1'b1, 32'h1},
        '{8'h08, 32'hA, 1'b1, 32'hA}, '{8'h08, 32'hE, 1'b1, 32'hE},
        '{8'h08, 32'h12, 1'b1, 32'h12}, '{8'h08, 32'h16, 1'b1, 32'h16},
        '{8'h08, 32'h4, 1'b0, 32'h16}, '{8'h08, 32'h3, 1'b1, 32'h3},
        '{8'h10, 32'h0, 1'b1, 32'h0}, '{8'h10, 32'h2, 1'b0, 32'h0},
        '{8'h14, 32'h3938701, 1'b0, 32'h3E8}, '{8'h14, 32'h3938700, 1'b1, 32'h3938700},
        '{8'h14, 32'h0, 1'b0, 32'h3938700}, '{8'h18, 32'h3E9, 1'b0, 32'h1E},
        '{8'h1C, 32'h100, 1'b0, 32'h0}, '{8'h1C, 32'hFF, 1'b1, 32'hFF},
        '{8'h20, 32'h21, 1'b0, 32'h1}, '{8'h20, 32'h0, 1'b0, 32'h1},
        '{8'h20, 32'h20, 1'b1, 32'h20}, '{8'h28, 32'hC, 1'b0, 32'h0},
        '{8'h28, 32'hB, 1'b1, 32'hB}, '{8'h34, 32'h2, 1'b0, 32'h0},
        '{8'h38, 32'h2, 1'b0, 32'h0}, '{8'h3C, 32'h3, 1'b0, 32'h2},
        '{8'h3C, 32'h1, 1'b1, 32'h1}, '{8'h40, 32'hFFFFFFF5, 1'b0, 32'h28},
        '{8'h40, 32'h51, 1'b0, 32'h28}, '{8'h40, 32'hFFFFFFF6, 1'b1, 32'hFFFFFFF6},
        '{8'h24, 32'h123, 1'b1, 32'h123}, '{8'h24, 32'h1000, 1'b0, 32'h123},
        '{8'h2C, 32'h0, 1'b1, 32'h0}, '{8'h30, 32'h0, 1'b1, 32'h0},
        '{8'h34, 32'h1, 1'b1, 32'h1}, '{8'h38, 32'h1, 1'b1, 32'h1},
        '{8'h4C, 32'h5, 1'b0, 32'h0}};
    cam_cmd dut (.CLK_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .CMD_OK_O,
        .CMD_ERR_O, .USER_OUTPUT_ZERO_I, .CTRL_LINE1_I, .TIMER_ZERO_ACTIVE_I,
        .INPUT_LINE_ZERO_I, .FRAME_REQ_I, .EXPOSE_O, .EXP_START_O, .PIX_I, .PIX_O, .TEMP_I,
        .FAN_O);
    cmd_host host (.clk_i(CLK_I), .addr_o(ADDR_I), .wdata_o(WDATA_I), .wr_o(WR_I),
        .rd_o(RD_I), .rdata_i(RDATA_O), .ok_i(CMD_OK_O), .err_i(CMD_ERR_O));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, s);
            mismatches++;
        end
    endtask
    // settings move to the active copy only on a frame request edge
    task automatic frame();
        @(posedge CLK_I);
        FRAME_REQ_I <= 1'b1;
        repeat (5) @(posedge CLK_I);
        FRAME_REQ_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
    endtask
    task automatic summarize();
        if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        CLK_I = 1'b0;
        forever #12.5 CLK_I = ~CLK_I;
    end
    initial begin
        // over two hundred times the length of the whole sequence
        #2000000;
        mismatches++;
        summarize();
    end
    initial begin
        RST_I = 1'b1;
        {FRAME_REQ_I, USER_OUTPUT_ZERO_I, CTRL_LINE1_I, TIMER_ZERO_ACTIVE_I} = 4'h0;
        INPUT_LINE_ZERO_I = 1'b1;
        TEMP_I = 8'h1E;
        PIX_I = '0;
        repeat (8) @(posedge CLK_I);
        RST_I <= 1'b0;
        foreach (rows[i]) begin
            host.put(rows[i].a, rows[i].d, ok, err);
            chk("ack", {30'h0, rows[i].ok, !rows[i].ok}, {30'h0, ok, err});
            host.get(rows[i].a, rd);
            chk("value", rows[i].r, rd);
        end
        host.put(8'h14, 32'h2, ok, err);
        host.put(8'h1C, 32'h5, ok, err);
        host.put(8'h20, 32'h2, ok, err);
        chk("fan before frame", 32'h0, {31'h0, FAN_O});
        frame();
        chk("fan on", 32'h1, {31'h0, FAN_O});
        @(posedge CLK_I);
        PIX_I <= '{valid: 1'b1, data: 12'h00A};
        @(posedge CLK_I);
        // second pixel jumps by more than the hot threshold over the first
        PIX_I <= '{valid: 1'b1, data: 12'h30A};
        #1;
        chk("pixel", 32'h125F, {19'h0, PIX_O});
        @(posedge CLK_I);
        PIX_I <= '0;
        #1;
        chk("hot pixel", 32'h125F, {19'h0, PIX_O});
        host.put(8'h0C, 32'h0, ok, err);
        @(posedge CLK_I);
        #1;
        chk("sw start", 32'h1, {31'h0, EXP_START_O});
        n = 0;
        repeat (100) @(posedge CLK_I) n += EXPOSE_O;
        chk("exposure length", 32'h1, {31'h0, n >= 41 && n <= 80});
        host.put(8'h08, 32'h16, ok, err);
        host.put(8'h3C, 32'h0, ok, err);
        frame();
        chk("fan off", 32'h0, {31'h0, FAN_O});
        INPUT_LINE_ZERO_I <= 1'b0;
        n = 0;
        repeat (8) @(posedge CLK_I) n += EXP_START_O;
        chk("pin falling start", 32'h1, n);
        chk("width on", 32'h1, {31'h0, EXPOSE_O});
        INPUT_LINE_ZERO_I <= 1'b1;
        repeat (4) @(posedge CLK_I);
        #1;
        chk("width end", 32'h0, {31'h0, EXPOSE_O});
        @(posedge CLK_I);
        RST_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        RST_I <= 1'b0;
        host.get(8'h00, rd);
        chk("reset trigger mode", 32'h0, rd);
        summarize();
    end
endmodule
